/* logic/fwg_defs.svh */
// Timing constants for the floppy write gate and erase controller.
`ifndef FWG_DEFS_SVH
`define FWG_DEFS_SVH
`define FWG_CLK_HZ           10000000
`define FWG_ERASE_ON_US      400
`define FWG_ERASE_OFF_US     800
`define FWG_ERASE_ON_CYC     ((`FWG_ERASE_ON_US * (`FWG_CLK_HZ / 1000000)))
`define FWG_ERASE_OFF_CYC    ((`FWG_ERASE_OFF_US * (`FWG_CLK_HZ / 1000000)))
`define FWG_READ_PULSE_NS    500
`define FWG_CLK_PERIOD_NS    100
`define FWG_READ_PULSE_CYC   ((`FWG_READ_PULSE_NS + `FWG_CLK_PERIOD_NS - 1) / `FWG_CLK_PERIOD_NS)
`define FWG_CNT_W            14
`define FWG_RP_W             4
`define FWG_SYNC_IDLE        7'h1F
`endif

/* logic/fwg_pkg.sv */
// Types for the floppy write gate and erase controller.
package fwg_pkg;
   typedef enum logic [1:0] {
      ERASE_OFF,
      ERASE_WAIT_ON,
      ERASE_ON,
      ERASE_WAIT_OFF
   } fwg_erase_t;

   typedef struct packed {
      logic headA;
      logic headB;
   } fwg_head_t;
endpackage

/* logic/fwg_write_erase_ctrl.sv */
// Floppy drive write gating, head toggle, erase timing and read pulse shaping.
`include "fwg_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module fwg_write_erase_ctrl
   import fwg_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic resetn,
   input  wire logic writeGateLine_n,
   input  wire logic writePulseLine_n,
   input  wire logic protectTabSwitch,
   input  wire logic stepperMoving,
   input  wire logic driveSelect_n,
   input  wire logic supplyGood,
   input  wire logic readComparator,
   output logic      readPulseLine_n,
   output logic      writeInProgress,
   output logic      writeCurrentEn,
   output fwg_head_t headDrive,
   output logic      eraseDrive
);
   // All asynchronous inputs pass two flip-flops before use.
   localparam int NIN = 7;
   // Synchroniser reset levels: every interface line reads false, protect
   // and stepper read busy and the comparator reads low. Nothing can start a
   // write, and the edge detectors see no false edge when reset ends.
   localparam logic [NIN-1:0] IN_IDLE = `FWG_SYNC_IDLE;
   localparam int NSHOT = 2;
   logic [1:0]              rstSync_r;
   logic                    rstn;
   logic [NIN-1:0]          inRaw;
   logic [NIN-1:0]          inS1_r;
   logic [NIN-1:0]          inS2_r;
   logic                    gateT;
   logic                    pulseT;
   logic                    protT;
   logic                    stepT;
   logic                    selT;
   logic                    supT;
   logic                    cmpS;
   logic                    cmpPrev_r;
   logic                    wpPrev_r;
   logic                    writeCtl;
   logic                    readHold;
   fwg_erase_t              eraseState_r;
   logic [`FWG_CNT_W-1:0]   eraseCnt_r;
   logic                    toggle_r;
   wire logic [NSHOT-1:0]   shotOn;

   // One edge decode serves the write pulse and both read one-shots.
   // A true third argument selects the rising edge, false the falling one.
   function automatic logic edge_seen(input logic cur,
                                      input logic prev,
                                      input logic rising);
      return rising ? (cur && !prev) : (!cur && prev);
   endfunction

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) rstSync_r <= 2'h0;
      else rstSync_r <= {rstSync_r[0], 1'b1};
   end
   assign rstn = rstSync_r[1];

   assign inRaw = {readComparator, supplyGood, driveSelect_n, stepperMoving,
                   protectTabSwitch, writePulseLine_n, writeGateLine_n};
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         inS1_r <= IN_IDLE;
         inS2_r <= IN_IDLE;
      end else begin
         inS1_r <= inRaw;
         inS2_r <= inS1_r;
      end
   end

   // Interface lines are low true; local switch levels are high true.
   assign gateT  = ~inS2_r[0];
   assign pulseT = ~inS2_r[1];
   assign protT  = inS2_r[2];
   assign stepT  = inS2_r[3];
   assign selT   = ~inS2_r[4];
   assign supT   = inS2_r[5];
   assign cmpS   = inS2_r[6];

   // Stepper busy blocks writing for its whole stepping cycle.
   assign writeCtl = gateT & ~protT & ~stepT & selT;

   // Write-in-progress ignores the supply; only the current drivers are gated,
   // so a supply dip stops head current while the host still sees a write.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         writeInProgress <= 1'b0;
         writeCurrentEn  <= 1'b0;
      end else begin
         writeInProgress <= writeCtl;
         writeCurrentEn  <= writeCtl & supT;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) wpPrev_r <= 1'b0;
      else wpPrev_r <= pulseT;
   end

   // Toggle on the trailing edge of each write pulse; cleared when idle.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) toggle_r <= 1'b0;
      else if (!writeCtl) toggle_r <= 1'b0;
      else if (edge_seen(pulseT, wpPrev_r, 1'b0)) toggle_r <= ~toggle_r;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) headDrive <= '{headA: 1'b1, headB: 1'b1};
      else if (!writeCtl) headDrive <= '{headA: 1'b1, headB: 1'b1};
      else headDrive <= '{headA: toggle_r, headB: ~toggle_r};
   end

   // Erase delays are counted; a short write drop restarts the on delay.
   // Counters make both delays exact to one clock, and a write that returns
   // during the off delay keeps erase on without a gap in the tunnel band.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         eraseState_r <= ERASE_OFF;
         eraseCnt_r   <= '0;
      end else begin
         case (eraseState_r)
            ERASE_OFF: begin
               eraseCnt_r <= '0;
               if (writeCtl) eraseState_r <= ERASE_WAIT_ON;
            end
            ERASE_WAIT_ON: begin
               if (!writeCtl) begin
                  eraseState_r <= ERASE_OFF;
                  eraseCnt_r   <= '0;
               end else if (eraseCnt_r == `FWG_CNT_W'(`FWG_ERASE_ON_CYC - 1)) begin
                  eraseState_r <= ERASE_ON;
                  eraseCnt_r   <= '0;
               end else eraseCnt_r <= eraseCnt_r + 1'b1;
            end
            ERASE_ON: begin
               eraseCnt_r <= '0;
               if (!writeCtl) eraseState_r <= ERASE_WAIT_OFF;
            end
            ERASE_WAIT_OFF: begin
               if (writeCtl) begin
                  eraseState_r <= ERASE_ON;
                  eraseCnt_r   <= '0;
               end else if (eraseCnt_r == `FWG_CNT_W'(`FWG_ERASE_OFF_CYC - 1)) begin
                  eraseState_r <= ERASE_OFF;
                  eraseCnt_r   <= '0;
               end else eraseCnt_r <= eraseCnt_r + 1'b1;
            end
            default: begin
               eraseState_r <= ERASE_OFF;
               eraseCnt_r   <= '0;
            end
         endcase
      end
   end

   // Erase driver output is active low, as an open-collector erase stage expects.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) eraseDrive <= 1'b1;
      else eraseDrive <= ~((eraseState_r == ERASE_ON) ||
                           (eraseState_r == ERASE_WAIT_OFF));
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) cmpPrev_r <= 1'b0;
      else cmpPrev_r <= cmpS;
   end

   // Deselect or an active write clears both one-shots at once.
   assign readHold = !selT || writeCtl;

   // Shot 0 fires on falling comparator edges, shot 1 on rising ones. A new
   // edge restarts a running shot rather than stretching it, so the read line
   // stays low until the later of the two shots has run out.
   genvar gi;
   generate
      for (gi = 0; gi < NSHOT; gi++) begin : gShot
         logic [`FWG_RP_W-1:0] cnt_r;
         always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
               cnt_r <= '0;
            end else if (readHold) begin
               cnt_r <= '0;
            end else if (edge_seen(cmpS, cmpPrev_r, gi == 1)) begin
               cnt_r <= `FWG_RP_W'(`FWG_READ_PULSE_CYC);
            end else if (cnt_r != '0) begin
               cnt_r <= cnt_r - 1'b1;
            end
         end
         assign shotOn[gi] = (cnt_r != '0);
      end
   endgenerate

   // Both shots share the one read line, low true toward the host.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) readPulseLine_n <= 1'b1;
      else readPulseLine_n <= ~(|shotOn);
   end
endmodule
`default_nettype wire

/* sim/fwg_write_erase_ctrl_chk.sv */
// Port-level checks for the write gate and erase controller.
`timescale 1ns/100ps
`default_nettype none
module fwg_write_erase_chk
   import fwg_pkg::*;
(
   input wire logic      core_clk,
   input wire logic      resetn,
   input wire logic      writeGateLine_n,
   input wire logic      writePulseLine_n,
   input wire logic      protectTabSwitch,
   input wire logic      stepperMoving,
   input wire logic      driveSelect_n,
   input wire logic      supplyGood,
   input wire logic      readComparator,
   input wire logic      readPulseLine_n,
   input wire logic      writeInProgress,
   input wire logic      writeCurrentEn,
   input wire fwg_head_t headDrive,
   input wire logic      eraseDrive
);
   wire block = writeGateLine_n | protectTabSwitch | stepperMoving | driveSelect_n;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // Five cycles of settled inputs cover the two-stage input synchroniser.
   chk_gate_blocks: assert property (block[*5] |-> !writeInProgress) else $error("bad wip");
   chk_gate_opens: assert property ((!block)[*5] |-> writeInProgress) else $error("no wip");
   chk_no_supply: assert property ((!supplyGood)[*5] |-> !writeCurrentEn) else $error("cur");
   chk_head_idle: assert property ((!writeInProgress)[*3] |-> headDrive == 2'b11) else $error("hd");
   chk_head_split: assert property (writeInProgress[*3] |-> ^headDrive) else $error("hd split");
   chk_read_desel: assert property (driveSelect_n[*6] |-> readPulseLine_n) else $error("rd");
   chk_read_write: assert property (writeInProgress[*2] |-> readPulseLine_n) else $error("rd");
   chk_read_width: assert property ($fell(readPulseLine_n) |-> !readPulseLine_n[*5]) else $error("w");
   cover property ($fell(eraseDrive));
   cover property ($rose(eraseDrive));
   cover property ($fell(readPulseLine_n));
endmodule
bind fwg_write_erase_ctrl fwg_write_erase_chk u_chk (.*);
`default_nettype wire

/* sim/fwg_host_model.sv */
// Host side write data source with a fixed pulse cadence.
`timescale 1ns/100ps
`default_nettype none
module fwg_host_model (
   input wire logic core_clk,
   input wire logic en,
   output logic     writePulseLine_n
);
   logic [2:0] ph_r = 3'h0;
   always @(negedge core_clk) ph_r <= ph_r + 3'h1;
   // Terminated line rests high, which means false.
   assign writePulseLine_n = !(en && ph_r < 3'h3);
endmodule
`default_nettype wire

/* sim/test_fwg_write_erase_ctrl.sv */
// Self-checking bench for the write gate and erase controller.
`timescale 1ns/100ps
`default_nettype none
module test_fwg_write_erase_ctrl;
   import fwg_pkg::*;
   logic core_clk = 0, resetn = 0, writeGateLine_n = 1, protectTabSwitch = 0, en = 0;
   logic stepperMoving = 0, driveSelect_n = 0, supplyGood = 1, readComparator = 0;
   logic writePulseLine_n, readPulseLine_n, writeInProgress, writeCurrentEn, eraseDrive;
   fwg_head_t headDrive;
   int mismatches = 0, compares = 0, seed = 78433, n;
   logic [3:0] v;
   always #50 core_clk = !core_clk;
   fwg_write_erase_ctrl DUT (.*);
   fwg_host_model host (.core_clk, .en, .writePulseLine_n);
   function automatic logic want_wip(input logic [3:0] c);
      return c == 4'h0;
   endfunction
   task automatic chk(input logic ok);
      compares++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("ERROR at %0t: output mismatch", $time);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge core_clk);
   endtask
   task automatic end_sim;
      $display("mismatches=%0d compares=%0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic erase_wait(input logic lvl);
      for (n = 0; eraseDrive !== lvl; n++) begin
         if (n > 9000) begin
            mismatches++;
            end_sim;
         end
         cyc(1);
      end
   endtask
   initial begin
      cyc(3);
      resetn = 1;
      cyc(4);
      chk(readPulseLine_n && !writeInProgress && headDrive === 2'b11 && eraseDrive);
      repeat (8) begin
         readComparator = !readComparator;
         for (n = 0; n < 8 && readPulseLine_n !== 1'b0; n++) cyc(1);
         chk(n < 8);
         cyc(6 + {$random(seed)} % 4);
      end
      driveSelect_n = 1;
      cyc(4);
      readComparator = !readComparator;
      for (n = 0; n < 10; n++) begin
         cyc(1);
         chk(readPulseLine_n === 1'b1);
      end
      // Walk every gating combination, then random ones.
      for (int i = 0; i < 32; i++) begin
         v = (i < 16) ? i[3:0] : 4'($random(seed));
         {writeGateLine_n, protectTabSwitch, stepperMoving, driveSelect_n} = v;
         supplyGood = 1'($random(seed));
         cyc(6);
         chk(writeInProgress === want_wip(v));
         chk(writeCurrentEn === (want_wip(v) & supplyGood));
         chk(want_wip(v) ? ^headDrive === 1'b1 : headDrive === 2'b11);
      end
      {writeGateLine_n, protectTabSwitch, stepperMoving, driveSelect_n} = 4'h0;
      supplyGood = 1;
      cyc(6);
      en = 1;
      repeat (4) begin
         v[1:0] = headDrive;
         for (n = 0; n < 12 && headDrive === v[1:0]; n++) cyc(1);
         chk(n < 12 && ^headDrive === 1'b1);
      end
      en = 0;
      writeGateLine_n = 1;
      cyc(10);
      writeGateLine_n = 0;
      erase_wait(0);
      chk(n >= 4000 && n <= 4008);
      writeGateLine_n = 1;
      erase_wait(1);
      chk(n >= 8000 && n <= 8008);
      // A write shorter than the turn-on delay must never start erase.
      writeGateLine_n = 0;
      cyc(2000);
      writeGateLine_n = 1;
      repeat (90) begin
         cyc(100);
         chk(eraseDrive === 1'b1);
      end
      end_sim;
   end
endmodule
`default_nettype wire
